// ==== verilog/csd_pkg.sv ====
// Purpose: constants for the channel diagnostic record
// Assumes: 125 MHz system clock, byte-indexed record read port
// Notes: record indices follow the record layout; timestamp is one 32-bit entry
//
// What this block does
// - Channel kind byte holds kind code in bits 6..0, bit 7 zero.
// - Diagnostic bits per channel byte reads constant eight.
// - Channel count byte reads constant four.
// - Summary byte bit n set when channel group n has an error.
// - Channel fault byte bit 0 set on configuration or parameter error.
// - Channel fault byte bit 4 set on wire-break; other bits reserved.
// - Timestamp captures the microsecond counter when a diagnostic event is recorded.
// - Microsecond counter starts from zero at power-on.
// - Counter advances once per microsecond and wraps after 2^32-1.
// - Module diagnostic bit 3 set whenever any channel error is present.
// - Wire-break reported only for channels whose enable bit is one.
// - Any error lights its channel indicator and enters the record.
package csd_pkg;
	// ----------------------------------------
	// Record indices
	// ----------------------------------------
	localparam logic [7:0] IDX_KIND = 8'h06;
	localparam logic [7:0] IDX_BITS = 8'h07;
	localparam logic [7:0] IDX_COUNT = 8'h08;
	localparam logic [7:0] IDX_SUMMARY = 8'h09;
	localparam logic [7:0] IDX_CHAN0 = 8'h0a;
	localparam logic [7:0] IDX_STAMP = 8'h13;
	// ----------------------------------------
	// Field values and positions
	// ----------------------------------------
	localparam logic [6:0] KIND_DIG_IN = 7'h70;
	localparam logic [6:0] KIND_ANA_IN = 7'h71;
	localparam logic [6:0] KIND_DIG_OUT = 7'h72;
	localparam logic [6:0] KIND_ANA_OUT = 7'h73;
	localparam logic [6:0] KIND_ANA_IO = 7'h74;
	localparam logic [6:0] KIND_COUNTER = 7'h76;
	localparam logic [7:0] DIAG_BITS = 8'h08;
	localparam logic [7:0] CHAN_COUNT = 8'h04;
	localparam int NUM_CHAN = 4;
	localparam int FAULT_PAR_BIT = 0;
	localparam int FAULT_WB_BIT = 4;
	localparam int MOD_CHAN_ERR_BIT = 3;
	localparam logic [31:0] STAMP_RESET = 32'h0000_0000;
	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 8;
	localparam int TICK_NS = 1000;
	localparam int CYCLES_PER_US = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PRESCALE_W = $clog2(CYCLES_PER_US);
endpackage : csd_pkg

// ==== verilog/csd_us_timer.sv ====
// Purpose: free-running microsecond counter
// Assumes: synchronous active-low reset stands for power-on
// Notes: counter wraps naturally at its width
`timescale 1ns/100ps
module csd_us_timer #(
	parameter int CNT_W = 32
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	output logic [CNT_W-1:0] us_count_q
);
	import csd_pkg::*;

	// ----------------------------------------
	// Prescaler and counter
	// ----------------------------------------
	localparam logic [PRESCALE_W-1:0] PRE_LAST = PRESCALE_W'(CYCLES_PER_US - 1);
	logic [PRESCALE_W-1:0] pre_q;
	logic [PRESCALE_W-1:0] pre_d;
	logic [CNT_W-1:0] us_count_d;
	wire tick = (pre_q == PRE_LAST);

	assign pre_d = tick ? '0 : pre_q + 1'b1;
	// Wrap after the all-ones value comes for free from the adder width
	assign us_count_d = tick ? us_count_q + 1'b1 : us_count_q;

	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			pre_q <= '0;
			us_count_q <= '0;
		end
		else
		begin
			pre_q <= pre_d;
			us_count_q <= us_count_d;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	AST_COUNT_STEP: assert property (@(posedge clk_sys) disable iff (!rst_n)
		$changed(us_count_q) |-> (us_count_q == $past(us_count_q) + 1'b1) && $past(tick))
		else $error("Counter moved by other than one tick");
	AST_COUNT_ZERO: assert property (@(posedge clk_sys)
		!rst_n |=> us_count_q == '0)
		else $error("Counter not zero after power-on");
	COV_TICK: cover property (@(posedge clk_sys) disable iff (!rst_n) tick ##1 $changed(us_count_q));
endmodule : csd_us_timer

// ==== verilog/csd_diag_record.sv ====
// Purpose: read-only diagnostic record of a four-channel analog output
// Assumes: fault inputs synchronous to clk_sys; one read per cycle at most
// Notes: read data appears one cycle after rd_en; unmapped indices read zero
`timescale 1ns/100ps
module csd_diag_record #(
	parameter logic [6:0] CHAN_KIND = csd_pkg::KIND_ANA_OUT
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [csd_pkg::NUM_CHAN-1:0] param_err,
	input wire logic [csd_pkg::NUM_CHAN-1:0] wire_break,
	input wire logic [csd_pkg::NUM_CHAN-1:0] wb_enable,
	input wire logic rd_en,
	input wire logic [7:0] rd_index,
	output logic [31:0] rd_data_q,
	output logic rd_valid_q,
	output logic [csd_pkg::NUM_CHAN-1:0] chan_led_q,
	output logic mod_chan_err_q
);
	import csd_pkg::*;

	// ----------------------------------------
	// Time base
	// ----------------------------------------
	logic [31:0] us_count;

	csd_us_timer #(
		.CNT_W(32)
	) u_timer (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.us_count_q(us_count)
	);

	// ----------------------------------------
	// Fault capture
	// ----------------------------------------
	logic [NUM_CHAN-1:0] fault_par_q;
	logic [NUM_CHAN-1:0] fault_wb_q;
	logic [31:0] stamp_q;
	logic [31:0] stamp_d;
	wire [NUM_CHAN-1:0] wb_err = wire_break & wb_enable;
	wire [NUM_CHAN-1:0] summary_d = param_err | wb_err;
	wire [NUM_CHAN-1:0] summary = fault_par_q | fault_wb_q;
	// An event is a fault bit that was clear and is now set
	wire new_event = |((param_err & ~fault_par_q) | (wb_err & ~fault_wb_q));

	// Later events overwrite the stamp; only the newest one is kept
	assign stamp_d = new_event ? us_count : stamp_q;

	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			fault_par_q <= '0;
			fault_wb_q <= '0;
			stamp_q <= STAMP_RESET;
			chan_led_q <= '0;
			mod_chan_err_q <= 1'b0;
		end
		else
		begin
			fault_par_q <= param_err;
			fault_wb_q <= wb_err;
			stamp_q <= stamp_d;
			chan_led_q <= summary_d;
			mod_chan_err_q <= |summary_d;
		end
	end

	// ----------------------------------------
	// Record read port
	// ----------------------------------------
	logic [7:0] chan_byte [NUM_CHAN];
	logic [NUM_CHAN-1:0] chan_hit;
	logic [7:0] chan_sel;

	genvar gi;
	generate
		for (gi = 0; gi < NUM_CHAN; gi++)
		begin : g_chan
			// Reserved bits tie low
			assign chan_byte[gi] = (8'(fault_par_q[gi]) << FAULT_PAR_BIT)
				| (8'(fault_wb_q[gi]) << FAULT_WB_BIT);
			assign chan_hit[gi] = (rd_index == IDX_CHAN0 + 8'(gi));
		end
	endgenerate

	always_comb
	begin
		chan_sel = '0;
		for (int i = 0; i < NUM_CHAN; i++)
		begin
			if (chan_hit[i])
				chan_sel = chan_byte[i];
		end
	end

	wire hit_kind = (rd_index == IDX_KIND);
	wire hit_bits = (rd_index == IDX_BITS);
	wire hit_count = (rd_index == IDX_COUNT);
	wire hit_summary = (rd_index == IDX_SUMMARY);
	wire hit_stamp = (rd_index == IDX_STAMP);
	wire [31:0] rd_data_d =
		hit_kind ? {25'h0, CHAN_KIND} :
		hit_bits ? {24'h0, DIAG_BITS} :
		hit_count ? {24'h0, CHAN_COUNT} :
		hit_summary ? {28'h0, summary} :
		(|chan_hit) ? {24'h0, chan_sel} :
		hit_stamp ? stamp_q :
		32'h0000_0000;

	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			rd_data_q <= '0;
			rd_valid_q <= 1'b0;
		end
		else
		begin
			rd_valid_q <= rd_en;
			if (rd_en)
				rd_data_q <= rd_data_d;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);

	AST_KIND_READ: assert property (
		rd_en && rd_index == IDX_KIND |=> rd_valid_q && rd_data_q == {25'h0, CHAN_KIND})
		else $error("Channel kind read wrong");
	AST_BITS_READ: assert property (
		rd_en && rd_index == IDX_BITS |=> rd_data_q == 32'h0000_0008)
		else $error("Diagnostic bit count read wrong");
	AST_COUNT_READ: assert property (
		rd_en && rd_index == IDX_COUNT |=> rd_data_q == 32'h0000_0004)
		else $error("Channel count read wrong");
	AST_SUMMARY_READ: assert property (
		rd_en && rd_index == IDX_SUMMARY
		|=> rd_data_q == {28'h0, $past(fault_par_q | fault_wb_q)})
		else $error("Summary byte does not match channel faults");
	AST_CHAN_BYTE: assert property (
		rd_en && (|chan_hit)
		|=> rd_data_q[31:8] == 24'h0 && rd_data_q[7:5] == 3'h0 && rd_data_q[3:1] == 3'h0)
		else $error("Reserved channel bits not zero");
	AST_PAR_FAULT: assert property (
		param_err[0] |=> fault_par_q[0] && chan_led_q[0])
		else $error("Parameter fault not recorded");
	AST_WB_GATED: assert property (
		(wire_break & ~wb_enable) != 4'h0 |=> (fault_wb_q & ~$past(wb_enable)) == 4'h0)
		else $error("Wire-break reported on a disabled channel");
	AST_WB_SET: assert property (
		wire_break[1] && wb_enable[1] |=> fault_wb_q[1] && chan_led_q[1])
		else $error("Enabled wire-break not recorded");
	AST_MOD_ERR: assert property (
		mod_chan_err_q == (|chan_led_q))
		else $error("Module channel error bit disagrees with channel faults");
	AST_STAMP_CAPTURE: assert property (
		new_event |=> stamp_q == $past(us_count))
		else $error("Timestamp not captured on event");
	AST_STAMP_HOLD: assert property (
		!new_event |=> $stable(stamp_q))
		else $error("Timestamp moved without an event");

	COV_EVENT: cover property (new_event ##1 rd_en && rd_index == IDX_STAMP);
	COV_WB: cover property (wire_break[1] && wb_enable[1] ##1 chan_led_q[1]);
	COV_SUMMARY: cover property (rd_en && rd_index == IDX_SUMMARY && summary != 4'h0);
endmodule : csd_diag_record

// ==== verification/csd_host_model.sv ====
// Purpose: reader standing in for the bus coupler
// Assumes: read answer one cycle after the request edge
// Notes: released index shows the inverse, not the last value
`timescale 1ns/100ps
module csd_host_model (
	input wire logic clk_sys,
	output logic rd_en,
	output logic [7:0] rd_index,
	input wire logic [31:0] rd_data_q,
	input wire logic rd_valid_q
);
	initial
	begin
		rd_en = 1'b0;
		rd_index = 8'h00;
	end
	// A missing valid pulse is turned into a value no read returns
	task automatic read(input logic [7:0] idx, output logic [31:0] d);
		@(posedge clk_sys);
		#1 rd_en = 1'b1;
		rd_index = idx;
		@(posedge clk_sys);
		#1 d = (rd_valid_q === 1'b1) ? rd_data_q : 32'hdead_beef;
		rd_en = 1'b0;
		rd_index = ~idx;
	endtask : read
endmodule : csd_host_model

// ==== verification/tb.sv ====
// Purpose: self-checking bench for the diagnostic record
// Assumes: 125 MHz clock, reset held 10 cycles
// Notes: stamp expectations rely on 125-cycle microsecond ticks
`timescale 1ns/100ps
module tb;
	import csd_pkg::*;
	logic clk_sys;
	logic rst_n;
	logic [3:0] param_err;
	logic [3:0] wire_break;
	logic [3:0] wb_enable;
	logic rd_en;
	logic [7:0] rd_index;
	logic [31:0] rd_data_q;
	logic [31:0] d;
	logic rd_valid_q;
	logic [3:0] chan_led_q;
	logic mod_chan_err_q;
	int miscompares = 0;
	int compares = 0;
	csd_diag_record u_dut (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.param_err(param_err),
		.wire_break(wire_break),
		.wb_enable(wb_enable),
		.rd_en(rd_en),
		.rd_index(rd_index),
		.rd_data_q(rd_data_q),
		.rd_valid_q(rd_valid_q),
		.chan_led_q(chan_led_q),
		.mod_chan_err_q(mod_chan_err_q)
	);
	csd_host_model u_host (
		.clk_sys(clk_sys),
		.rd_en(rd_en),
		.rd_index(rd_index),
		.rd_data_q(rd_data_q),
		.rd_valid_q(rd_valid_q)
	);
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic rd(input logic [7:0] i, input logic [31:0] e);
		u_host.read(i, d);
		chk(d, e);
	endtask : rd
	task final_report;
		if (miscompares == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : final_report
	initial
	begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end
	initial
	begin
		repeat (5000) @(posedge clk_sys);
		miscompares++;
		final_report;
	end
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		rst_n = 1'b0;
		param_err = 4'h0;
		wire_break = 4'h0;
		wb_enable = 4'h2;
		repeat (10) @(posedge clk_sys);
		#1 rst_n = 1'b1;
		rd(8'h06, 32'h0000_0073);
		rd(8'h07, 32'h0000_0008);
		rd(8'h08, 32'h0000_0004);
		rd(8'h0e, 32'h0000_0000);
		// Channel 2 breaks with recognition off, so it must stay silent
		@(posedge clk_sys);
		#1 param_err = 4'h1;
		wire_break = 4'h4;
		repeat (2) @(posedge clk_sys);
		#1;
		chk(32'(chan_led_q), 32'h0000_0001);
		chk(32'(mod_chan_err_q), 32'h0000_0001);
		rd(8'h09, 32'h0000_0001);
		rd(8'h0a, 32'h0000_0001);
		rd(8'h0c, 32'h0000_0000);
		rd(8'h13, 32'h0000_0000);
		repeat (400) @(posedge clk_sys);
		#1 wire_break = 4'h6;
		repeat (2) @(posedge clk_sys);
		rd(8'h13, 32'h0000_0003);
		rd(8'h0b, 32'h0000_0010);
		rd(8'h09, 32'h0000_0003);
		chk(32'(chan_led_q), 32'h0000_0003);
		repeat (200) @(posedge clk_sys);
		rd(8'h13, 32'h0000_0003);
		@(posedge clk_sys);
		#1 param_err = 4'h0;
		wire_break = 4'h0;
		repeat (2) @(posedge clk_sys);
		#1;
		chk(32'(mod_chan_err_q), 32'h0000_0000);
		rd(8'h09, 32'h0000_0000);
		final_report;
	end
endmodule : tb
